// ===== acc_consts.svh
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// =====================================================================
// register offsets
`define ACC_OFF_CLK    12'h000
`define ACC_OFF_START  12'h004
`define ACC_OFF_MODE   12'h008
`define ACC_OFF_STAT   12'h080
// =====================================================================
// field positions
`define ACC_SH_MSB     7
`define ACC_SH_LSB     4
`define ACC_DIV_MSB    2
`define ACC_START_NORM 0
`define ACC_START_PRIO 1
`define ACC_MODE_REF   7
`define ACC_MODE_PSRC  3
`define ACC_MODE_PEN   2
`define ACC_MODE_NSRC  1
`define ACC_MODE_NEN   0
// =====================================================================
// reset values
`define ACC_SH_RST     4'h0
`define ACC_DIV_RST    3'h0
// =====================================================================
// timing counts in conversion clocks
`define ACC_SH_C0      7'h0A
`define ACC_SH_C1      7'h14
`define ACC_SH_C2      7'h1E
`define ACC_SH_C3      7'h28
`define ACC_SH_C4      7'h50
`define ACC_CONV_CLKS  7'h1E
`define ACC_MIN_CLKS   7'h28
`endif

// ===== acc_pkg.sv
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_IDLE    = 3'b001,
    ACC_SAMPLE  = 3'b010,
    ACC_CONVERT = 3'b100
  } acc_state_t;
endpackage

// ===== acc_conv_seq.sv
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_conv_seq (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // launch
  input  wire logic       i_start,
  input  wire logic       i_prio,
  input  wire logic [2:0] i_div_sel,
  input  wire logic [3:0] i_sh_sel,
  // converter core
  output logic            o_tick,
  output logic            o_busy,
  output logic            o_prio,
  output logic            o_sample,
  output logic            o_convert,
  output logic            o_done
);
  // =====================================================================
  // decoders
  function automatic logic [2:0] div_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    div_limit = 3'h0;
      3'h1:    div_limit = 3'h1;
      3'h2:    div_limit = 3'h3;
      default: div_limit = 3'h7; // reserved codes run slowest
    endcase
  endfunction

  function automatic logic [6:0] sh_clocks(input logic [3:0] sel);
    case (sel)
      4'h0:    sh_clocks = `ACC_SH_C0;
      4'h1:    sh_clocks = `ACC_SH_C1;
      4'h2:    sh_clocks = `ACC_SH_C2;
      4'h3:    sh_clocks = `ACC_SH_C3;
      4'h4:    sh_clocks = `ACC_SH_C4;
      default: sh_clocks = `ACC_SH_C0;
    endcase
  endfunction

  // =====================================================================
  // prescaler
  logic [2:0]            div_cnt;
  logic                  div_hit;
  assign div_hit = (div_cnt == div_limit(i_div_sel));
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt <= 3'h0;
      o_tick  <= 1'b0;
    end else begin
      div_cnt <= div_hit ? 3'h0 : div_cnt + 3'h1;
      o_tick  <= div_hit;
    end
  end

  // =====================================================================
  // sample then convert
  acc_pkg::acc_state_t   state;
  acc_pkg::acc_state_t   next_state;
  logic [6:0]            left;
  logic [6:0]            next_left;
  logic                  next_done;
  always_comb begin
    next_state = state;
    next_left  = left;
    next_done  = 1'b0;
    case (state)
      acc_pkg::ACC_IDLE: begin
        if (i_start) begin
          next_state = acc_pkg::ACC_SAMPLE;
          next_left  = sh_clocks(i_sh_sel) - 7'h01;
        end
      end
      acc_pkg::ACC_SAMPLE: begin
        if (o_tick && left == 7'h00) begin
          next_state = acc_pkg::ACC_CONVERT;
          next_left  = `ACC_CONV_CLKS - 7'h01;
        end else if (o_tick) begin
          next_left = left - 7'h01;
        end
      end
      acc_pkg::ACC_CONVERT: begin
        if (o_tick && left == 7'h00) begin
          next_state = acc_pkg::ACC_IDLE;
          next_done  = 1'b1;
        end else if (o_tick) begin
          next_left = left - 7'h01;
        end
      end
      default: begin
        next_state = acc_pkg::ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state  <= acc_pkg::ACC_IDLE;
      left   <= 7'h00;
      o_done <= 1'b0;
      o_prio <= 1'b0;
    end else begin
      state  <= next_state;
      left   <= next_left;
      o_done <= next_done;
      if (state == acc_pkg::ACC_IDLE && i_start) begin
        o_prio <= i_prio;
      end
    end
  end

  assign o_busy    = (state != acc_pkg::ACC_IDLE);
  assign o_sample  = (state == acc_pkg::ACC_SAMPLE);
  assign o_convert = (state == acc_pkg::ACC_CONVERT);

  // =====================================================================
  // checks
  logic [6:0]            sh_lat;
  logic [7:0]            ticks_run;
  logic [3:0]            gap;
  logic                  seen_tick;
  logic [2:0]            div_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_lat    <= `ACC_SH_C0;
      ticks_run <= 8'h00;
      gap       <= 4'h0;
      seen_tick <= 1'b0;
      div_q     <= 3'h0;
    end else begin
      if (state == acc_pkg::ACC_IDLE && i_start) begin
        sh_lat    <= sh_clocks(i_sh_sel);
        ticks_run <= 8'h00;
      end else if (o_busy && o_tick) begin
        ticks_run <= ticks_run + 8'h01;
      end
      gap       <= o_tick ? 4'h1 : gap + 4'h1;
      div_q     <= i_div_sel;
      // divider change: first tick after it is not a full period
      seen_tick <= (i_div_sel != div_q) ? 1'b0 : (seen_tick | o_tick);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  // spacing holds only while the divider setting is left alone
  tick_spacing_a: assert property (
    o_tick && seen_tick && $stable(i_div_sel)
      |-> gap == {1'b0, div_limit(i_div_sel)} + 4'h1)
    else $error("conversion clock spacing wrong");
  sample_length_a: assert property (
    $rose(o_convert) |-> ticks_run == {1'b0, sh_lat})
    else $error("sample-hold length wrong");
  conv_total_a: assert property (
    o_done |-> ticks_run == {1'b0, sh_lat} + {1'b0, `ACC_CONV_CLKS}
      && ticks_run >= {1'b0, `ACC_MIN_CLKS})
    else $error("conversion shorter than required");
  cover_long_sh_c: cover property (o_done && sh_lat == `ACC_SH_C4);
endmodule

// ===== acc_ctrl.sv
`timescale 1ns/10ps
`include "acc_consts.svh"
// Operation
// - sample-hold field codes 0 to 4 give 10, 20, 30, 40, 80 clocks
// - prescaler field codes 0 to 3 divide fast clock by 1, 2, 4, 8
// - each conversion lasts at least forty conversion clocks including sampling
// - writing one to priority start launches priority conversion; reads zero
// - writing one to normal start launches normal conversion; reads zero
// - shared external trigger starts only the priority conversion
// - hardware normal starts occur only while their enable bit is one
module acc_ctrl (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // trigger sources
  input  wire logic        i_ext_trig,
  input  wire logic        i_prio_timer_trig,
  input  wire logic        i_norm_timer_trig,
  // converter core
  output logic             o_ref_enable,
  output logic             o_conv_tick,
  output logic             o_sample,
  output logic             o_convert,
  output logic             o_conv_prio,
  output logic             o_prio_done,
  output logic             o_norm_done
);
  // =====================================================================
  // control registers
  logic [3:0]              sh_sel;
  logic [2:0]              div_sel;
  logic                    prio_src;
  logic                    prio_en;
  logic                    norm_src;
  logic                    norm_en;
  logic                    pend_prio;
  logic                    pend_norm;
  logic                    next_pend_prio;
  logic                    next_pend_norm;
  logic                    seq_busy;
  logic                    seq_prio;
  logic                    seq_done;

  // =====================================================================
  // apb decode
  wire hit_clk   = (i_paddr == `ACC_OFF_CLK);
  wire hit_start = (i_paddr == `ACC_OFF_START);
  wire hit_mode  = (i_paddr == `ACC_OFF_MODE);
  wire hit_stat  = (i_paddr == `ACC_OFF_STAT);
  wire unmapped  = !(hit_clk || hit_start || hit_mode || hit_stat);
  wire setup     = i_psel && !i_penable;
  wire wr_acc    = i_psel && i_penable && i_pwrite;
  wire wr_clk    = wr_acc && hit_clk;
  wire wr_start  = wr_acc && hit_start;
  wire wr_mode   = wr_acc && hit_mode;

  // start bits and reserved bits read as zero
  wire [31:0] rd_clk  = {24'h0, sh_sel, 1'b0, div_sel};
  wire [31:0] rd_mode = {24'h0, o_ref_enable, 3'h0,
                         prio_src, prio_en, norm_src, norm_en};
  wire [31:0] rd_stat = {28'h0, pend_prio, pend_norm,
                         seq_busy && seq_prio, seq_busy && !seq_prio};
  wire [31:0] rd_value = hit_clk  ? rd_clk  :
                         hit_mode ? rd_mode :
                         hit_stat ? rd_stat : 32'h0;

  // zero-wait access phase; data captured in the setup cycle
  assign o_pready = i_psel && i_penable;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0 : rd_value;
      o_pslverr <= unmapped;
    end
  end

  // only documented fields are stored; other bits are dropped
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_sel  <= `ACC_SH_RST;
      div_sel <= `ACC_DIV_RST;
    end else if (wr_clk) begin
      sh_sel  <= i_pwdata[`ACC_SH_MSB:`ACC_SH_LSB];
      div_sel <= i_pwdata[`ACC_DIV_MSB:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ref_enable <= 1'b0;
      prio_src     <= 1'b0;
      prio_en      <= 1'b0;
      norm_src     <= 1'b0;
      norm_en      <= 1'b0;
    end else if (wr_mode) begin
      o_ref_enable <= i_pwdata[`ACC_MODE_REF];
      prio_src     <= i_pwdata[`ACC_MODE_PSRC];
      prio_en      <= i_pwdata[`ACC_MODE_PEN];
      norm_src     <= i_pwdata[`ACC_MODE_NSRC];
      norm_en      <= i_pwdata[`ACC_MODE_NEN];
    end
  end

  // =====================================================================
  // external trigger synchroniser
  logic                    ext_s1;
  logic                    ext_s2;
  logic                    ext_s3;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= i_ext_trig;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // =====================================================================
  // start sources and arbitration
  wire ext_rise  = ext_s2 && !ext_s3;
  wire prio_ext  = prio_en && !prio_src;
  wire hw_prio   = prio_en && (prio_src ? i_prio_timer_trig : ext_rise);
  wire hw_norm   = norm_en && (norm_src ? i_norm_timer_trig
                                        : ext_rise && !prio_ext);
  wire sw_prio   = wr_start && i_pwdata[`ACC_START_PRIO];
  wire sw_norm   = wr_start && i_pwdata[`ACC_START_NORM];
  wire set_prio  = sw_prio || hw_prio;
  wire set_norm  = sw_norm || hw_norm;
  // priority request always served first when the sequencer frees up
  wire take_prio = !seq_busy && pend_prio;
  wire take_norm = !seq_busy && !pend_prio && pend_norm;

  // a new start in the launch cycle survives: set wins
  assign next_pend_prio = set_prio || (pend_prio && !take_prio);
  assign next_pend_norm = set_norm || (pend_norm && !take_norm);

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_prio <= 1'b0;
      pend_norm <= 1'b0;
    end else begin
      pend_prio <= next_pend_prio;
      pend_norm <= next_pend_norm;
    end
  end

  // =====================================================================
  // sequencer
  acc_conv_seq u_seq (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_start   (take_prio || take_norm),
    .i_prio    (take_prio),
    .i_div_sel (div_sel),
    .i_sh_sel  (sh_sel),
    .o_tick    (o_conv_tick),
    .o_busy    (seq_busy),
    .o_prio    (seq_prio),
    .o_sample  (o_sample),
    .o_convert (o_convert),
    .o_done    (seq_done)
  );

  assign o_conv_prio = seq_busy && seq_prio;
  assign o_prio_done = seq_done && seq_prio;
  assign o_norm_done = seq_done && !seq_prio;

  // =====================================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  prio_start_a: assert property (
    sw_prio |=> pend_prio || o_sample)
    else $error("priority start lost");
  norm_start_a: assert property (
    sw_norm |=> pend_norm || (o_sample && !seq_prio))
    else $error("normal start lost");
  start_reads_a: assert property (
    setup && !i_pwrite && hit_start |=> o_prdata == 32'h0)
    else $error("start register read not zero");
  shared_trig_a: assert property (
    ext_rise && prio_ext && norm_en && !norm_src && !pend_norm && !sw_norm
      |=> pend_prio && !pend_norm)
    else $error("shared trigger started normal conversion");
  hw_enable_a: assert property (
    !norm_en && !pend_norm && !sw_norm |=> !pend_norm)
    else $error("normal conversion started while disabled");
  reserved_zero_a: assert property (
    setup && !i_pwrite && (hit_clk || hit_mode)
      |=> o_prdata[31:8] == 24'h0
        && ($past(hit_clk) ? !o_prdata[3] : o_prdata[6:4] == 3'h0))
    else $error("reserved bits read nonzero");
  prio_first_a: assert property (
    pend_prio && pend_norm && !seq_busy |=> o_sample && seq_prio)
    else $error("priority not served first");
  field_write_a: assert property (
    wr_clk |=> sh_sel == $past(i_pwdata[7:4]) && div_sel == $past(i_pwdata[2:0]))
    else $error("clock setting not stored");

  cover_prio_c: cover property (o_prio_done);
  cover_norm_c: cover property (o_norm_done);
  cover_clash_c: cover property (ext_rise && prio_ext && norm_en && !norm_src);
endmodule

// ===== acc_core_model.sv
`timescale 1ns/10ps
// =====================================================================
// converter core stand-in: counts conversion clocks per phase
module acc_core_model (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // from control block
  input  wire logic       i_tick,
  input  wire logic       i_sample,
  input  wire logic       i_convert,
  input  wire logic       i_prio,
  // measurements
  output logic [7:0]      o_samp_ticks,
  output logic [7:0]      o_conv_ticks,
  output logic [7:0]      o_tick_gap,
  output logic            o_last_prio
);
  logic       sample_q;
  logic [7:0] gap_cnt;
  // counts restart at each sample start so a stale run never leaks in
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sample_q     <= 1'b0;
      gap_cnt      <= 8'h00;
      o_samp_ticks <= 8'h00;
      o_conv_ticks <= 8'h00;
      o_tick_gap   <= 8'h00;
      o_last_prio  <= 1'b0;
    end else begin
      sample_q <= i_sample;
      gap_cnt  <= i_tick ? 8'h00 : gap_cnt + 8'h01;
      if (i_tick) begin
        o_tick_gap <= gap_cnt + 8'h01;
      end
      if (i_sample && !sample_q) begin
        o_samp_ticks <= {7'h00, i_tick};
        o_conv_ticks <= 8'h00;
        o_last_prio  <= i_prio;
      end else if (i_sample && i_tick) begin
        o_samp_ticks <= o_samp_ticks + 8'h01;
      end else if (i_convert && i_tick) begin
        o_conv_ticks <= o_conv_ticks + 8'h01;
      end
    end
  end
endmodule

// ===== acc_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_ctrl_tb_top;
  // =====================================================================
  // signals
  logic        i_clk_sys;
  logic        i_arst_n;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic        i_ext_trig;
  logic        i_prio_timer_trig;
  logic        i_norm_timer_trig;
  logic        o_ref_enable;
  logic        o_conv_tick;
  logic        o_sample;
  logic        o_convert;
  logic        o_conv_prio;
  logic        o_prio_done;
  logic        o_norm_done;
  logic [7:0]  samp;
  logic [7:0]  conv;
  logic [7:0]  gap;
  logic        lprio;
  logic [31:0] rd;
  logic        er;
  logic [1:0]  w;
  int          c;
  int          error_cnt;
  int          total_checks;
  int          cyc_cnt;
  logic [7:0]  sh_len [5] = '{8'h0A, 8'h14, 8'h1E, 8'h28, 8'h50};
  // =====================================================================
  // instances
  acc_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_ext_trig(i_ext_trig), .i_prio_timer_trig(i_prio_timer_trig),
    .i_norm_timer_trig(i_norm_timer_trig), .o_ref_enable(o_ref_enable),
    .o_conv_tick(o_conv_tick), .o_sample(o_sample), .o_convert(o_convert),
    .o_conv_prio(o_conv_prio), .o_prio_done(o_prio_done), .o_norm_done(o_norm_done));
  acc_core_model u_core (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_tick(o_conv_tick),
    .i_sample(o_sample), .i_convert(o_convert), .i_prio(o_conv_prio),
    .o_samp_ticks(samp), .o_conv_ticks(conv), .o_tick_gap(gap), .o_last_prio(lprio));
  // =====================================================================
  // clock and timeout
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  // =====================================================================
  // tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr_en;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_er);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, exp_er});
  endtask
  // clock setting only changes with reference off, then 3 us settle
  task automatic set_clk(input logic [31:0] v);
    apb(1'b1, `ACC_OFF_MODE, 32'h0);
    apb(1'b1, `ACC_OFF_CLK, v);
    apb(1'b1, `ACC_OFF_MODE, 32'h80);
    repeat (375) @(posedge i_clk_sys);
  endtask
  task automatic wait_done(input int lim);
    w = 2'b00;
    c = 0;
    while (w === 2'b00 && c < lim) begin
      @(posedge i_clk_sys);
      c++;
      w = {o_prio_done, o_norm_done};
    end
  endtask
  task automatic pulse(input int sel);
    @(posedge i_clk_sys);
    if (sel == 0) i_ext_trig <= 1'b1;
    else if (sel == 1) i_norm_timer_trig <= 1'b1;
    else i_prio_timer_trig <= 1'b1;
    // external pin held a few cycles to cross its synchroniser
    repeat ((sel == 0) ? 4 : 1) @(posedge i_clk_sys);
    i_ext_trig        <= 1'b0;
    i_norm_timer_trig <= 1'b0;
    i_prio_timer_trig <= 1'b0;
  endtask
  // =====================================================================
  // tests
  initial begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_ext_trig, i_prio_timer_trig, i_norm_timer_trig} = 3'h0;
    {error_cnt, total_checks, cyc_cnt} = '0;
    i_arst_n = 1'b0;
    repeat (16) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    rdchk(`ACC_OFF_CLK, 32'h0, 1'b0);
    rdchk(`ACC_OFF_MODE, 32'h0, 1'b0);
    apb(1'b1, `ACC_OFF_CLK, 32'hFFFFFFFF);
    rdchk(`ACC_OFF_CLK, 32'h000000F7, 1'b0);
    apb(1'b1, `ACC_OFF_MODE, 32'hFFFFFFFF);
    rdchk(`ACC_OFF_MODE, 32'h0000008F, 1'b0);
    rdchk(12'h100, 32'h0, 1'b1);
    set_clk(32'h2);
    chk(32'(o_ref_enable), 32'h1);
    apb(1'b1, `ACC_OFF_START, 32'hFFFFFFFC);
    wait_done(300);
    chk(32'(w), 32'h0);
    // sample lengths at /4, a legal rate for this clock
    for (int i = 0; i < 5; i++) begin
      set_clk(32'(i << 4) | 32'h2);
      apb(1'b1, `ACC_OFF_START, 32'h1);
      wait_done(1000);
      chk(32'(w), 32'h1);
      chk(32'(samp), 32'(sh_len[i]));
      chk(32'(conv), 32'h1E);
      chk(32'(lprio), 32'h0);
    end
    // codes 0 and 1 break the rate limit here; run only to reach every code
    for (int i = 0; i < 4; i++) begin
      set_clk(32'(i));
      apb(1'b1, `ACC_OFF_START, 32'h2);
      wait_done(1000);
      chk(32'(w), 32'h2);
      chk(32'(gap), 32'(1 << i));
      chk(32'(c >= (39 << i) + 3), 32'h1);
      chk(32'(lprio), 32'h1);
      rdchk(`ACC_OFF_START, 32'h0, 1'b0);
    end
    set_clk(32'h2);
    apb(1'b1, `ACC_OFF_MODE, 32'h85);
    pulse(0);
    wait_done(600);
    chk(32'(w), 32'h2);
    wait_done(600);
    chk(32'(w), 32'h0);
    apb(1'b1, `ACC_OFF_MODE, 32'h81);
    pulse(0);
    wait_done(600);
    chk(32'(w), 32'h1);
    apb(1'b1, `ACC_OFF_MODE, 32'h82);
    pulse(1);
    wait_done(600);
    chk(32'(w), 32'h0);
    apb(1'b1, `ACC_OFF_MODE, 32'h83);
    pulse(1);
    wait_done(600);
    chk(32'(w), 32'h1);
    apb(1'b1, `ACC_OFF_MODE, 32'h8C);
    pulse(2);
    wait_done(600);
    chk(32'(w), 32'h2);
    // both starts at once: priority first, normal held pending
    apb(1'b1, `ACC_OFF_START, 32'h3);
    rdchk(`ACC_OFF_STAT, 32'h6, 1'b0);
    wait_done(600);
    chk(32'(w), 32'h2);
    chk(32'(lprio), 32'h1);
    wait_done(600);
    chk(32'(w), 32'h1);
    chk(32'(lprio), 32'h0);
    end_sim();
  end
endmodule
